/* File: core/mul8_pkg.sv */
// package for the apb-attached 8x8 unsigned multiplier
package mul8_pkg;
	localparam logic [11:0] MUL8_OFF_WORKING  = 12'h000;
	localparam logic [11:0] MUL8_OFF_FILE_OP  = 12'h004;
	localparam logic [11:0] MUL8_OFF_PROD_LO  = 12'h008;
	localparam logic [11:0] MUL8_OFF_PROD_HI  = 12'h00c;
	localparam logic [11:0] MUL8_OFF_STATUS   = 12'h010;
	localparam logic [7:0]  MUL8_RST_BYTE     = 8'h00;
	localparam logic [7:0]  MUL8_RST_STATUS   = 8'h00;

	typedef struct packed {
		logic [7:0] working_register;
		logic [7:0] product_high_byte;
		logic [7:0] product_low_byte;
		logic [7:0] arith_status_register;
		logic       pready;
		logic       pslverr;
		logic [31:0] prdata;
	} mul8_state_s;
endpackage

/* File: core/mul8_top.sv */
// apb register block wrapping a single-cycle 8x8 unsigned multiplier
// Function
// - a multiply finishes and writes its product in the single cycle of the command.
// - both operands are unsigned and the full 16-bit product is kept.
// - the top product byte goes to the high byte register, the bottom to the low one.
// - a multiply never alters any bit of the arithmetic status register.
// - one operand is the working register, the other the byte written as file operand.
//
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/1ps
module mul8_top
	import mul8_pkg::*;
(
	input  wire logic        MCLK,
	input  wire logic        RST,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR
);
	// array widths; the bus carries each operand byte in the low lane of the word
	localparam int OP_W   = 8;
	localparam int PROD_W = 2 * OP_W;

	mul8_state_s                      st_r;
	mul8_state_s                      st_nxt;
	logic                             access_first;
	logic                             access_last;
	logic                             wr_commit;
	logic                             rd_capture;
	logic                             sel_working;
	logic                             sel_file_op;
	logic                             sel_prod_lo;
	logic                             sel_prod_hi;
	logic                             sel_status;
	logic                             known;
	logic        [OP_W-1:0]           op_work;
	logic        [OP_W-1:0]           op_file;
	wire logic   [OP_W:0][PROD_W-1:0] pp_sum;
	logic        [PROD_W-1:0]         product;

	// the first access edge raises ready; the edge that sees ready completes the transfer
	assign access_first = PSEL && PENABLE && !st_r.pready;
	assign access_last  = PSEL && PENABLE && st_r.pready;

	// one select per register word
	assign sel_working = (PADDR == MUL8_OFF_WORKING);
	assign sel_file_op = (PADDR == MUL8_OFF_FILE_OP);
	assign sel_prod_lo = (PADDR == MUL8_OFF_PROD_LO);
	assign sel_prod_hi = (PADDR == MUL8_OFF_PROD_HI);
	assign sel_status  = (PADDR == MUL8_OFF_STATUS);
	assign known       = sel_working || sel_file_op || sel_prod_lo ||
		sel_prod_hi || sel_status;

	// an unmapped write is dropped, so it can never disturb a stored byte
	assign wr_commit  = access_last && PWRITE && known;
	assign rd_capture = access_first && !PWRITE;

	// the command's operands: the working register and the write data byte
	assign op_work = st_r.working_register;
	assign op_file = PWDATA[OP_W-1:0];

	// shift-and-add array of ripple adders; it settles within the clock of the command,
	// trading a long combinational path for a product that never needs a wait state
	assign pp_sum[0] = '0;
	for (genvar i = 0; i < OP_W; i++) begin : g_row
		wire logic [PROD_W-1:0] row;
		wire logic [PROD_W-1:0] prop;
		wire logic [PROD_W-1:0] gen;
		wire logic [PROD_W-1:0] carry;
		// no sign extension: both operands are plain unsigned bytes
		assign row      = op_file[i] ? (PROD_W'(op_work) << i) : '0;
		assign carry[0] = 1'b0;
		for (genvar j = 0; j < PROD_W; j++) begin : g_bit
			assign prop[j]        = pp_sum[i][j] ^ row[j];
			assign gen[j]         = pp_sum[i][j] & row[j];
			assign pp_sum[i+1][j] = prop[j] ^ carry[j];
			// no carry leaves the top bit: an 8 by 8 product always fits in 16 bits
			if (j < PROD_W - 1) begin : g_carry
				assign carry[j+1] = gen[j] | (carry[j] & prop[j]);
			end
		end
	end
	assign product = pp_sum[OP_W];

	always_comb begin
		st_nxt         = st_r;
		// ready and error are one-cycle answers raised by the first access edge only
		st_nxt.pready  = access_first;
		st_nxt.pslverr = access_first && !known;
		st_nxt.prdata  = 32'h0000_0000;
		if (rd_capture) begin
			case (PADDR)
				MUL8_OFF_WORKING: begin
					st_nxt.prdata = {24'h000000, st_r.working_register};
				end
				MUL8_OFF_PROD_LO: begin
					st_nxt.prdata = {24'h000000, st_r.product_low_byte};
				end
				MUL8_OFF_PROD_HI: begin
					st_nxt.prdata = {24'h000000, st_r.product_high_byte};
				end
				MUL8_OFF_STATUS: begin
					st_nxt.prdata = {24'h000000, st_r.arith_status_register};
				end
				// the file operand is write-only and reads back as zero without an error
				default: begin
					st_nxt.prdata = 32'h0000_0000;
				end
			endcase
		end

		// writes land on the edge at which the master sees ready
		if (wr_commit) begin
			case (PADDR)
				MUL8_OFF_WORKING: begin
					st_nxt.working_register = PWDATA[7:0];
				end
				MUL8_OFF_FILE_OP: begin
					// writing the file operand is the multiply command; both bytes on one edge
					st_nxt.product_high_byte = product[15:8];
					st_nxt.product_low_byte  = product[7:0];
				end
				MUL8_OFF_PROD_LO: begin
					st_nxt.product_low_byte = PWDATA[7:0];
				end
				MUL8_OFF_PROD_HI: begin
					st_nxt.product_high_byte = PWDATA[7:0];
				end
				// status changes only by its own write, never as a side effect of a multiply
				MUL8_OFF_STATUS: begin
					st_nxt.arith_status_register = PWDATA[7:0];
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			st_r.working_register      <= MUL8_RST_BYTE;
			st_r.product_high_byte     <= MUL8_RST_BYTE;
			st_r.product_low_byte      <= MUL8_RST_BYTE;
			st_r.arith_status_register <= MUL8_RST_STATUS;
			st_r.pready                <= 1'b0;
			st_r.pslverr               <= 1'b0;
			st_r.prdata                <= 32'h0000_0000;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign PRDATA  = st_r.prdata;
	assign PREADY  = st_r.pready;
	assign PSLVERR = st_r.pslverr;
endmodule

/* File: verification/mul8_apb_m.sv */
// apb master standing for the execution logic
`timescale 1ns/1ps
module mul8_apb_m(input wire logic MCLK,PREADY,PSLVERR,input wire logic [31:0] PRDATA,
	output logic PSEL=0,PENABLE=0,PWRITE=0,output logic [11:0] PADDR=0,output logic [31:0] PWDATA=0);
logic last_err=0;
task io(input logic w,input logic [11:0] a,input logic [31:0] d,output logic [31:0] r);
	@(posedge MCLK) {PSEL,PWRITE,PADDR,PWDATA}<={1'b1,w,a,d};
	@(posedge MCLK) PENABLE<=1;
	// held until ready is seen; the bench timeout cuts a hang
	do @(posedge MCLK); while(PREADY!==1);
	r=PRDATA;
	last_err=PSLVERR;
	{PSEL,PENABLE}<=0;
endtask
endmodule

/* File: verification/mul8_top_sva.sv */
// port assertions for the multiplier block
`timescale 1ns/1ps
module mul8_top_sva(input wire logic MCLK,RST,PSEL,PENABLE,PWRITE,PREADY,PSLVERR,
	input wire logic [11:0] PADDR,input wire logic [31:0] PWDATA,PRDATA);
default clocking @(posedge MCLK); endclocking
default disable iff (RST);
a_one_wait: assert property(PSEL&&PENABLE&&!PREADY|=>PREADY) else $error("late");
a_ready_pulse: assert property(PREADY|=>!PREADY) else $error("long");
a_rd_narrow: assert property(PREADY|->PRDATA[31:8]==0) else $error("wide");
a_map_ok: assert property(PREADY&&PADDR<=12'h010&&PADDR[1:0]==0|->!PSLVERR) else $error("err");
a_op_rd_zero: assert property(PREADY&&!PWRITE&&PADDR==12'h004|->PRDATA==0) else $error("op");
a_err_unmapped: assert property(PREADY&&PADDR>12'h010|->PSLVERR) else $error("unmapped");
a_err_ready: assert property(PSLVERR|->PREADY) else $error("stray err");
c_mul: cover property(PREADY&&PWRITE&&PADDR==12'h004);
c_rd_hi: cover property(PREADY&&!PWRITE&&PADDR==12'h00c);
c_err: cover property(PSLVERR);
endmodule

/* File: verification/single_cycle_8x8_multiplier_tb.sv */
// self-checking bench for the multiplier block
`timescale 1ns/1ps
module single_cycle_8x8_multiplier_tb;
import mul8_pkg::*;
logic MCLK=0,RST=1,PSEL,PENABLE,PWRITE,PREADY,PSLVERR;
logic [11:0] PADDR;
logic [31:0] PWDATA,PRDATA,r;
logic [7:0] a[3]='{8'hff,8'h80,8'h0d},b[3]='{8'hff,8'h02,8'h00};
logic [15:0] p,q[4];
logic [31:0] acc;
int n_fail=0,cmp_count=0,cyc=0;
always #50 MCLK=~MCLK;
mul8_top i_dut(.*);
mul8_apb_m i_m(.*);
task chk(input logic [31:0] s,e);
	cmp_count++;
	if(s!==e) begin
		n_fail++;
		$display("[ERR] %0t %h %h",$time,s,e);
	end
endtask
task mul(input logic [7:0] x,y,output logic [15:0] o);
	i_m.io(1,MUL8_OFF_WORKING,{24'h0,x},r);
	i_m.io(1,MUL8_OFF_FILE_OP,{24'h0,y},r);
	i_m.io(0,MUL8_OFF_PROD_HI,0,r);
	o[15:8]=r[7:0];
	i_m.io(0,MUL8_OFF_PROD_LO,0,r);
	o[7:0]=r[7:0];
endtask
// software sign correction after the unsigned multiply
task smul(input logic [7:0] x,y,output logic [15:0] o);
	mul(x,y,o);
	if(x[7]) o[15:8]-=y;
	if(y[7]) o[15:8]-=x;
endtask
task finish_test;
	$display("fails %0d checks %0d",n_fail,cmp_count);
	if(n_fail==0&&cmp_count>0) $display("Result: passed");
	else $display("Result: failed");
	$finish;
endtask
always @(posedge MCLK) if(++cyc>2000) begin n_fail++; finish_test; end
initial begin
	repeat(8) @(posedge MCLK);
	RST<=0;
	i_m.io(1,MUL8_OFF_STATUS,32'ha5,r);
	for(int i=0;i<3;i++) begin
		mul(a[i],b[i],p);
		chk(p[15:8],(32'(a[i])*32'(b[i]))>>8);
		chk(p[7:0],(32'(a[i])*32'(b[i]))&32'hff);
	end
	chk(i_m.last_err,0);
	smul(8'hfe,8'h03,p);
	chk(p,32'h0000fffa);
	smul(8'hfe,8'hfd,p);
	chk(p,32'h00000006);
	mul(8'h34,8'hcd,q[0]);
	mul(8'h12,8'hcd,q[1]);
	mul(8'h34,8'hab,q[2]);
	mul(8'h12,8'hab,q[3]);
	acc=32'(q[0])+(32'(q[1])<<8)+(32'(q[2])<<8)+(32'(q[3])<<16);
	chk(acc,32'h1234*32'habcd);
	i_m.io(1,12'h014,32'h5a,r);
	chk(i_m.last_err,1);
	i_m.io(0,12'h014,0,r);
	chk(r,0);
	i_m.io(0,MUL8_OFF_FILE_OP,0,r);
	chk(r,0);
	chk(i_m.last_err,0);
	i_m.io(0,MUL8_OFF_STATUS,0,r);
	chk(r,32'ha5);
	finish_test;
end
endmodule
bind mul8_top mul8_top_sva u_sva(.*);
